// file: rpd_reset_power_down_control.sv
`timescale 1ns/1ns
`include "rpd_cfg.svh"
module rpd_reset_power_down_control
	import rpd_pkg::*;
#(
	parameter int BT_WIDTH = `RPD_BT_WIDTH
)
(
	input wire logic clk_i, // System clock.
	input wire logic resetn_i, // Synchronous reset, active low.
	input wire logic power_good_i, // Supply at operating level (pin domain).
	input wire logic ext_resetn_i, // Card reset pin, active low.
	input wire logic vdd_abnormal_i, // Supply detector out of range.
	input wire logic freq_abnormal_i, // Clock detector out of range.
	input wire logic abn_reset_en_i, // Security control: abnormal reset on.
	input wire logic clk_undivided_i, // Clock control: CPU clock undivided.
	input wire logic idle_req_i, // CPU executes idle, one-cycle pulse.
	input wire logic stop_req_i, // CPU executes stop, one-cycle pulse.
	input wire logic irq_i, // Pending interrupt, level.
	input wire logic bt_clear_i, // Software clears watchdog, pulse.
	output logic cpu_resetn_o, // CPU reset, active low.
	output logic cpu_clk_en_o, // CPU clock gate enable.
	output logic cpu_clk_div_o, // CPU clock divider toggle.
	output logic periph_clk_en_o, // Peripheral clock gate enable.
	output logic load_pc_o, // Pulse: load program counter.
	output logic [15:0] pc_value_o, // Program counter value to load.
	output logic wake_irq_o, // Pulse: interrupt wake; idle resumes, stop holds CPU reset then vectors.
	output logic vdd_abnormal_o, // Supply abnormal flag.
	output logic freq_abnormal_o, // Frequency abnormal flag.
	output logic [1:0] reset_cause_o // 0 power, 1 pin, 2 watchdog, 3 abnormal.
);
	initial
	begin
		if (BT_WIDTH < 2 || BT_WIDTH > 16)
			$error("BT_WIDTH out of range");
	end

	// ***********************************************
	// Input synchronisers
	// ***********************************************
	logic pg_s;
	logic pin_s;
	logic vab_s;
	logic fab_s;

	rpd_sync2 u_pg (.clk_i(clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
		.d_i(power_good_i), .q_o(pg_s));
	rpd_sync2 u_pin (.clk_i(clk_i), .resetn_i(resetn_i), .rst_val_i(1'b1),
		.d_i(ext_resetn_i), .q_o(pin_s));
	rpd_sync2 u_vab (.clk_i(clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
		.d_i(vdd_abnormal_i), .q_o(vab_s));
	rpd_sync2 u_fab (.clk_i(clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
		.d_i(freq_abnormal_i), .q_o(fab_s));

	// ***********************************************
	// Reset sources
	// ***********************************************
	rpd_state_t st_q;
	rpd_state_t st_d;
	logic [BT_WIDTH-1:0] bt_q;
	logic [BT_WIDTH-1:0] bt_d;
	logic pin_q;
	logic pin_d;
	logic [1:0] cause_q;
	logic [1:0] cause_d;
	logic bt_ovf;
	logic por_evt;
	logic pin_low;
	logic pin_rise;
	logic wdt_evt;
	logic abn_evt;
	logic any_src;

	assign bt_ovf = &bt_q;
	// Low supply itself is the trigger and holds reset until power-good rises.
	assign por_evt = !pg_s;
	// The sequence starts on release, so a held-low pin keeps reset asserted.
	assign pin_low = !pin_s;
	assign pin_rise = pin_s && !pin_q;
	assign wdt_evt = (st_q == RPD_ST_RUN) && bt_ovf;
	assign abn_evt = abn_reset_en_i && (vab_s || fab_s);
	assign any_src = por_evt || pin_low || pin_rise || wdt_evt || abn_evt;

	// ***********************************************
	// Sequencer
	// ***********************************************
	always_comb
	begin
		st_d = st_q;
		bt_d = bt_q + 1'b1;
		pin_d = pin_s;
		cause_d = cause_q;
		unique case (st_q)
			RPD_ST_RESET:
			begin
				bt_d = BT_WIDTH'(`RPD_BT_RESET);
				if (!any_src)
					st_d = RPD_ST_STAB;
			end
			RPD_ST_STAB:
				if (bt_ovf)
					st_d = RPD_ST_VECTOR;
			RPD_ST_VECTOR:
				st_d = RPD_ST_RUN;
			RPD_ST_RUN:
			begin
				if (bt_clear_i)
					bt_d = BT_WIDTH'(`RPD_BT_RESET);
				if (stop_req_i)
					st_d = RPD_ST_STOP;
				else if (idle_req_i)
					st_d = RPD_ST_IDLE;
			end
			RPD_ST_IDLE:
				if (irq_i)
					st_d = RPD_ST_RUN;
			RPD_ST_STOP:
			begin
				// The basic timer freezes; the CPU clock divider toggle keeps running.
				bt_d = bt_q;
				if (irq_i)
				begin
					// Stop wake must re-time the oscillator before running.
					bt_d = BT_WIDTH'(`RPD_BT_RESET);
					st_d = RPD_ST_STAB;
				end
			end
			default:
				st_d = RPD_ST_RESET;
		endcase
		if (any_src)
		begin
			st_d = RPD_ST_RESET;
			bt_d = BT_WIDTH'(`RPD_BT_RESET);
			if (por_evt)
				cause_d = 2'h0;
			else if (pin_low || pin_rise)
				cause_d = 2'h1;
			else if (wdt_evt)
				cause_d = 2'h2;
			else
				cause_d = 2'h3;
		end
		if (!resetn_i)
		begin
			st_d = RPD_ST_RESET;
			bt_d = BT_WIDTH'(`RPD_BT_RESET);
			pin_d = 1'b1;
			cause_d = 2'h0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		st_q <= st_d;
		bt_q <= bt_d;
		pin_q <= pin_d;
		cause_q <= cause_d;
	end

	// ***********************************************
	// Outputs
	// ***********************************************
	logic cpu_resetn_d;
	logic cpu_clk_en_d;
	logic cpu_clk_div_d;
	logic periph_clk_en_d;
	logic load_pc_d;
	logic [15:0] pc_value_d;
	logic wake_irq_d;
	logic vab_d;
	logic fab_d;
	logic vec_done_q;
	logic vec_done_d;

	always_comb
	begin
		// CPU stays in reset through the whole stabilization count.
		cpu_resetn_d = (st_d != RPD_ST_RESET)
			&& (st_d != RPD_ST_STAB);
		cpu_clk_en_d = (st_d == RPD_ST_RUN)
			|| (st_d == RPD_ST_VECTOR);
		periph_clk_en_d = (st_d != RPD_ST_STOP);
		cpu_clk_div_d = clk_undivided_i ? 1'b1 : !cpu_clk_div_o;
		load_pc_d = 1'b0;
		pc_value_d = pc_value_o;
		vec_done_d = vec_done_q;
		wake_irq_d = 1'b0;
		if (st_q == RPD_ST_STAB && st_d == RPD_ST_VECTOR)
		begin
			load_pc_d = 1'b1;
			pc_value_d = `RPD_RESET_VECTOR;
			vec_done_d = 1'b0;
		end
		else if (st_q == RPD_ST_VECTOR && !vec_done_q)
		begin
			// The vector jumps on to the application start.
			load_pc_d = 1'b1;
			pc_value_d = `RPD_APP_START;
			vec_done_d = 1'b1;
		end
		if ((st_q == RPD_ST_IDLE || st_q == RPD_ST_STOP) && irq_i && !any_src)
			wake_irq_d = 1'b1;
		vab_d = vab_s;
		fab_d = fab_s;
		if (!resetn_i)
		begin
			cpu_resetn_d = 1'b0;
			cpu_clk_en_d = 1'b0;
			cpu_clk_div_d = 1'b0;
			periph_clk_en_d = 1'b1;
			load_pc_d = 1'b0;
			pc_value_d = `RPD_RESET_VECTOR;
			vec_done_d = 1'b0;
			wake_irq_d = 1'b0;
			vab_d = 1'b0;
			fab_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		cpu_resetn_o <= cpu_resetn_d;
		cpu_clk_en_o <= cpu_clk_en_d;
		cpu_clk_div_o <= cpu_clk_div_d;
		periph_clk_en_o <= periph_clk_en_d;
		load_pc_o <= load_pc_d;
		pc_value_o <= pc_value_d;
		vec_done_q <= vec_done_d;
		wake_irq_o <= wake_irq_d;
		vdd_abnormal_o <= vab_d;
		freq_abnormal_o <= fab_d;
	end
	assign reset_cause_o = cause_q;

	// ***********************************************
	// Assertions
	// ***********************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	chk_por_holds_reset: assert property (!pg_s |=> !cpu_resetn_o)
		else $error("CPU reset released while supply low");
	chk_pin_low_reset: assert property (pin_low |=> !cpu_resetn_o)
		else $error("CPU reset released while pin low");
	chk_wdt_resets: assert property (wdt_evt |=> st_q == RPD_ST_RESET)
		else $error("Watchdog overflow did not reset");
	chk_stab_count: assert property (st_q == RPD_ST_STAB && !bt_ovf
		|-> !cpu_resetn_o || $past(st_q) != RPD_ST_STAB)
		else $error("CPU ran during stabilization");
	chk_vector_seq: assert property (load_pc_o && pc_value_o == 16'h0100
		|=> load_pc_o && pc_value_o == 16'h0400)
		else $error("Vector not followed by application start");
	chk_idle_gate: assert property (st_q == RPD_ST_IDLE && $past(st_q) ==
		RPD_ST_IDLE |-> !cpu_clk_en_o && periph_clk_en_o)
		else $error("Idle clock gating wrong");
	chk_stop_halt: assert property (st_q == RPD_ST_STOP && $past(st_q) ==
		RPD_ST_STOP |-> !periph_clk_en_o && $stable(bt_q))
		else $error("Stop did not halt");
	chk_abn_reset: assert property (abn_reset_en_i && vab_s |=>
		st_q == RPD_ST_RESET)
		else $error("Enabled abnormal reset ignored");
	chk_undivided: assert property (clk_undivided_i ##1 clk_undivided_i
		|-> cpu_clk_div_o)
		else $error("Undivided clock not selected");

	cov_watchdog: cover property (wdt_evt);
	cov_idle_wake: cover property (st_q == RPD_ST_IDLE ##1 st_q == RPD_ST_RUN);
	cov_stop_wake: cover property (st_q == RPD_ST_STOP ##1 st_q == RPD_ST_STAB);
endmodule : rpd_reset_power_down_control

// file: rpd_cfg.svh
`ifndef RPD_CFG_SVH
`define RPD_CFG_SVH

// ***********************************************
// Timing
// ***********************************************
`define RPD_CLK_MHZ 20
`define RPD_RST_LOW_NS 5000
`define RPD_RST_LOW_CYC ((`RPD_RST_LOW_NS * `RPD_CLK_MHZ + 999) / 1000)

// ***********************************************
// Addresses and reset values
// ***********************************************
`define RPD_RESET_VECTOR 16'h0100
`define RPD_APP_START 16'h0400
`define RPD_BT_WIDTH 8
`define RPD_BT_RESET 8'h00
`endif

// file: rpd_pkg.sv
package rpd_pkg;
	typedef enum logic [2:0]
	{
		RPD_ST_RESET = 3'b000,
		RPD_ST_STAB = 3'b001,
		RPD_ST_VECTOR = 3'b010,
		RPD_ST_RUN = 3'b011,
		RPD_ST_IDLE = 3'b100,
		RPD_ST_STOP = 3'b101
	} rpd_state_t;
endpackage : rpd_pkg

// file: rpd_sync2.sv
`timescale 1ns/1ns
module rpd_sync2
(
	input wire logic clk_i, // Clock.
	input wire logic resetn_i, // Synchronous reset, active low.
	input wire logic rst_val_i, // Value held during reset.
	input wire logic d_i, // Asynchronous level.
	output logic q_o // Synchronised level.
);
	logic s1_q;
	logic s1_d;
	logic s2_d;

	always_comb
	begin
		s1_d = d_i;
		s2_d = s1_q;
		if (!resetn_i)
		begin
			s1_d = rst_val_i;
			s2_d = rst_val_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		s1_q <= s1_d;
		q_o <= s2_d;
	end
endmodule : rpd_sync2

// file: rpd_reader.sv
`timescale 1ns/1ns
`include "rpd_cfg.svh"
module rpd_reader
#(
	parameter int LOW_CYC = `RPD_RST_LOW_CYC
)
(
	input wire logic clk_i, // Reader clock.
	input wire logic pwr_on_i, // Reader switches the supply on.
	input wire logic pulse_i, // Request one card reset pulse.
	output logic power_good_o, // Supply at operating level.
	output logic ext_resetn_o // Card reset pin, active low.
);
	int cnt_q = 0;
	assign power_good_o = pwr_on_i;
	assign ext_resetn_o = (cnt_q == 0);
	// The pin is never released early, so the width is always the minimum.
	always_ff @(posedge clk_i)
	begin
		if (pulse_i && cnt_q == 0)
			cnt_q <= LOW_CYC;
		else if (cnt_q != 0)
			cnt_q <= cnt_q - 1;
	end
endmodule : rpd_reader

// file: rpd_reset_power_down_control_tb.sv
`timescale 1ns/1ns
module rpd_reset_power_down_control_tb;
	import rpd_pkg::*;
	localparam int BTW = 4;
	logic clk_i = 0, resetn_i = 0, pwr_on = 0, pulse = 0, kick_en = 1;
	logic power_good_i, ext_resetn_i, vdd_abnormal_i = 0, freq_abnormal_i = 0;
	logic abn_reset_en_i = 0, clk_undivided_i = 0, idle_req_i = 0;
	logic stop_req_i = 0, irq_i = 0, bt_clear_i = 0;
	logic cpu_resetn_o, cpu_clk_en_o, cpu_clk_div_o, periph_clk_en_o;
	logic load_pc_o, wake_irq_o, vdd_abnormal_o, freq_abnormal_o;
	logic [15:0] pc_value_o;
	logic [1:0] reset_cause_o;
	logic [1:0] kc = 0;
	int err_total = 0, checked = 0, cyc = 0;
	rpd_reset_power_down_control #(.BT_WIDTH(BTW))
		rpd_reset_power_down_control_i (.clk_i(clk_i),
		.resetn_i(resetn_i), .power_good_i(power_good_i),
		.ext_resetn_i(ext_resetn_i), .vdd_abnormal_i(vdd_abnormal_i),
		.freq_abnormal_i(freq_abnormal_i),
		.abn_reset_en_i(abn_reset_en_i),
		.clk_undivided_i(clk_undivided_i), .idle_req_i(idle_req_i),
		.stop_req_i(stop_req_i), .irq_i(irq_i), .bt_clear_i(bt_clear_i),
		.cpu_resetn_o(cpu_resetn_o), .cpu_clk_en_o(cpu_clk_en_o),
		.cpu_clk_div_o(cpu_clk_div_o), .periph_clk_en_o(periph_clk_en_o),
		.load_pc_o(load_pc_o), .pc_value_o(pc_value_o),
		.wake_irq_o(wake_irq_o), .vdd_abnormal_o(vdd_abnormal_o),
		.freq_abnormal_o(freq_abnormal_o), .reset_cause_o(reset_cause_o));
	rpd_reader rpd_reader_i (.clk_i(clk_i), .pwr_on_i(pwr_on),
		.pulse_i(pulse), .power_good_o(power_good_i),
		.ext_resetn_o(ext_resetn_i));
	// ***********************************************
	// Clock, watchdog service and timeout
	// ***********************************************
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		kc <= kc + 2'h1;
		bt_clear_i <= kick_en && (kc == 2'h0);
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic ticks(input int n);
		repeat (n) @(negedge clk_i);
	endtask : ticks
	// Waits out the stabilisation count and checks the vector sequence.
	task automatic wait_vec();
		int n;
		n = 0;
		while (load_pc_o !== 1'b1 && n < 400)
		begin
			@(negedge clk_i);
			n++;
		end
		chk("load_pc_o", 16'h1, {15'h0, load_pc_o});
		chk("stab_long", 16'h1, {15'h0, n >= (1 << BTW)});
		chk("pc_vector", 16'h0100, pc_value_o);
		ticks(1);
		chk("pc_app", 16'h0400, pc_value_o);
		chk("cpu_run", 16'h1, {15'h0, cpu_resetn_o});
	endtask : wait_vec
	// ***********************************************
	// Scenarios
	// ***********************************************
	task automatic t_power_on();
		@(posedge clk_i) pwr_on <= 1;
		ticks(1);
		chk("cpu_held", 16'h0, {15'h0, cpu_resetn_o});
		wait_vec();
		chk("cause_pwr", 16'h0, {14'h0, reset_cause_o});
	endtask : t_power_on
	task automatic t_clock_div();
		logic a;
		int ch;
		ch = 0;
		@(posedge clk_i) clk_undivided_i <= 1;
		ticks(3);
		repeat (4)
		begin
			chk("div_undiv", 16'h1, {15'h0, cpu_clk_div_o});
			ticks(1);
		end
		@(posedge clk_i) clk_undivided_i <= 0;
		ticks(3);
		repeat (8)
		begin
			a = cpu_clk_div_o;
			ticks(1);
			ch += (a !== cpu_clk_div_o);
		end
		chk("div_toggles", 16'h1, {15'h0, ch > 0});
	endtask : t_clock_div
	task automatic t_power_down(input logic stop);
		int n;
		@(posedge clk_i)
		begin
			idle_req_i <= !stop;
			stop_req_i <= stop;
		end
		@(posedge clk_i)
		begin
			idle_req_i <= 0;
			stop_req_i <= 0;
		end
		ticks(3);
		chk("cpu_clk_off", 16'h0, {15'h0, cpu_clk_en_o});
		chk("periph_clk", {15'h0, !stop}, {15'h0, periph_clk_en_o});
		@(posedge clk_i) irq_i <= 1;
		if (stop)
			wait_vec();
		else
		begin
			n = 0;
			while (wake_irq_o !== 1'b1 && n < 20)
			begin
				@(negedge clk_i);
				n++;
			end
			chk("wake_irq", 16'h1, {15'h0, wake_irq_o});
			ticks(2);
			chk("cpu_clk_on", 16'h1, {15'h0, cpu_clk_en_o});
		end
		@(posedge clk_i) irq_i <= 0;
		ticks(4);
	endtask : t_power_down
	task automatic t_pin_reset();
		@(posedge clk_i) pulse <= 1;
		@(posedge clk_i) pulse <= 0;
		ticks(50);
		chk("pin_held", 16'h0, {15'h0, cpu_resetn_o});
		while (ext_resetn_i !== 1'b1)
			@(negedge clk_i);
		wait_vec();
		chk("cause_pin", 16'h1, {14'h0, reset_cause_o});
	endtask : t_pin_reset
	task automatic t_abnormal();
		@(posedge clk_i)
		begin
			vdd_abnormal_i <= 1;
			freq_abnormal_i <= 1;
		end
		ticks(10);
		chk("vdd_flag", 16'h1, {15'h0, vdd_abnormal_o});
		chk("freq_flag", 16'h1, {15'h0, freq_abnormal_o});
		chk("abn_off", 16'h1, {15'h0, cpu_resetn_o});
		@(posedge clk_i) abn_reset_en_i <= 1;
		ticks(6);
		chk("abn_on", 16'h0, {15'h0, cpu_resetn_o});
		chk("cause_abn", 16'h3, {14'h0, reset_cause_o});
		@(posedge clk_i)
		begin
			vdd_abnormal_i <= 0;
			freq_abnormal_i <= 0;
		end
		wait_vec();
		@(posedge clk_i) abn_reset_en_i <= 0;
	endtask : t_abnormal
	task automatic t_watchdog();
		int n;
		n = 0;
		@(posedge clk_i) kick_en <= 0;
		while (cpu_resetn_o !== 1'b0 && n < 100)
		begin
			@(negedge clk_i);
			n++;
		end
		chk("wdog_reset", 16'h0, {15'h0, cpu_resetn_o});
		chk("cause_wdog", 16'h2, {14'h0, reset_cause_o});
		@(posedge clk_i) kick_en <= 1;
		wait_vec();
	endtask : t_watchdog
	initial
	begin
		repeat (5) @(posedge clk_i);
		resetn_i <= 1;
		t_power_on();
		t_clock_div();
		t_power_down(1'b0);
		t_power_down(1'b1);
		t_pin_reset();
		t_abnormal();
		t_watchdog();
		conclude();
	end
endmodule : rpd_reset_power_down_control_tb
